/* rtl/aal_engine.sv */
// link engine with retry, auto ack and axi-lite regs
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "aal_consts.svh"
module aal_engine (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic chip_enable,
    output logic irq_n,
    output logic air_tx_valid,
    output logic [39:0] air_tx_address,
    output logic [31:0] air_tx_payload,
    output logic air_tx_is_ack,
    input wire logic air_tx_done,
    input wire logic air_rx_valid,
    input wire logic [39:0] air_rx_address,
    input wire logic [31:0] air_rx_payload,
    input wire logic air_rx_crc_ok,
    input wire logic air_rx_is_ack,
    output logic radio_power,
    output logic osc_16m_enable,
    output logic air_rate_2m
);
    aal_pkg::aal_state_t state_q;
    logic ce;
    logic ce_rise;
    logic ce_fall;
    logic cfg_rx_q, cfg_pwr_q, cfg_rate_q, cfg_retx_q;
    logic [5:0] auto_ack_q, pipe_en_q;
    logic [7:0] retr_q, channel_q;
    logic [39:0] p0_addr_q, p1_addr_q;
    logic [31:0] p_low_q;
    logic [2:0] status_q;
    logic [2:0] rx_pipe_q;
    logic [3:0] retry_cnt_q, lost_cnt_q;
    logic [31:0] tx_mem_q [`AAL_FIFO_DEPTH];
    logic [31:0] rx_mem_q [`AAL_FIFO_DEPTH];
    logic [1:0] tx_cnt_q, rx_cnt_q;
    logic [31:0] timer_q;
    logic [39:0] ack_addr_q;
    logic aw_q, w_q;
    logic [31:0] awaddr_q, wdata_q;
    logic wr_go;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic [5:0] hit;
    logic [2:0] hit_pipe;
    logic rx_ok;

    aal_sync u_ce_sync (
        .aclk(aclk), .aresetn(aresetn), .din(chip_enable),
        .dout(ce), .rise(ce_rise), .fall(ce_fall)
    );

    // write capture, aw and w in either order
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign wr_go = aw_q && w_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'h0;

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_rx_q <= 1'b0;
            cfg_pwr_q <= 1'b0;
            cfg_rate_q <= 1'b0;
            cfg_retx_q <= 1'b1;
            auto_ack_q <= `AAL_AUTO_ACK_RST;
            pipe_en_q <= `AAL_PIPE_ENABLE_RST;
            retr_q <= `AAL_RETR_RST;
            channel_q <= 8'h02;
            p0_addr_q <= 40'he7e7e7e7e7;
            p1_addr_q <= 40'hc2c2c2c2c2;
            p_low_q <= 32'hc6c5c4c3;
        end else if (wr_go) begin
            case (awaddr_q)
                `AAL_OFF_CONFIG: begin
                    cfg_rx_q <= wdata_q[0];
                    cfg_pwr_q <= wdata_q[1];
                    cfg_rate_q <= wdata_q[2];
                    cfg_retx_q <= wdata_q[3];
                end
                `AAL_OFF_AUTO_ACK: auto_ack_q <= wdata_q[5:0];
                `AAL_OFF_PIPE_EN: pipe_en_q <= wdata_q[5:0];
                `AAL_OFF_RETR: retr_q <= wdata_q[7:0];
                `AAL_OFF_CHANNEL: channel_q <= wdata_q[7:0];
                `AAL_OFF_P0_LO: p0_addr_q[31:0] <= wdata_q;
                `AAL_OFF_P0_HI: p0_addr_q[39:32] <= wdata_q[7:0];
                `AAL_OFF_P1_LO: p1_addr_q[31:0] <= wdata_q;
                `AAL_OFF_P1_HI: p1_addr_q[39:32] <= wdata_q[7:0];
                `AAL_OFF_P_LOW: p_low_q <= wdata_q;
                default: ;
            endcase
        end
    end

    // pipe address match
    always_comb begin
        hit[0] = air_rx_address == p0_addr_q;
        hit[1] = air_rx_address == p1_addr_q;
        hit[2] = air_rx_address == {p1_addr_q[39:8], p_low_q[7:0]};
        hit[3] = air_rx_address == {p1_addr_q[39:8], p_low_q[15:8]};
        hit[4] = air_rx_address == {p1_addr_q[39:8], p_low_q[23:16]};
        hit[5] = air_rx_address == {p1_addr_q[39:8], p_low_q[31:24]};
        hit = hit & pipe_en_q;
        hit_pipe = 3'h7;
        for (int i = `AAL_PIPES - 1; i >= 0; i--) begin
            if (hit[i]) hit_pipe = 3'(i);
        end
    end
    assign rx_ok = state_q == aal_pkg::AAL_RX_LISTEN && air_rx_valid
        && air_rx_crc_ok && !air_rx_is_ack && hit != 6'h0
        && rx_cnt_q != 2'(`AAL_FIFO_DEPTH);

    // fifo strobes from the bus and the air side
    assign tx_push = wr_go && awaddr_q == `AAL_OFF_TX_PUSH
        && tx_cnt_q != 2'(`AAL_FIFO_DEPTH);
    assign rx_pop = s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `AAL_OFF_RX_POP && rx_cnt_q != 2'h0;
    assign rx_push = rx_ok;
    assign tx_pop = state_q == aal_pkg::AAL_ACK_WAIT && air_rx_valid
        && air_rx_is_ack && air_rx_crc_ok && air_rx_address == p0_addr_q;

    // tx and rx fifos, shift-down flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_cnt_q <= 2'h0;
            rx_cnt_q <= 2'h0;
            for (int i = 0; i < `AAL_FIFO_DEPTH; i++) begin
                tx_mem_q[i] <= 32'h0;
                rx_mem_q[i] <= 32'h0;
            end
        end else begin
            if (tx_pop) begin
                for (int i = 0; i < `AAL_FIFO_DEPTH - 1; i++)
                    tx_mem_q[i] <= tx_mem_q[i + 1];
            end
            if (tx_push) tx_mem_q[tx_pop ? tx_cnt_q - 2'h1 : tx_cnt_q]
                <= wdata_q;
            tx_cnt_q <= tx_cnt_q + 2'(tx_push) - 2'(tx_pop);
            if (rx_pop) begin
                for (int i = 0; i < `AAL_FIFO_DEPTH - 1; i++)
                    rx_mem_q[i] <= rx_mem_q[i + 1];
            end
            if (rx_push) rx_mem_q[rx_pop ? rx_cnt_q - 2'h1 : rx_cnt_q]
                <= air_rx_payload;
            rx_cnt_q <= rx_cnt_q + 2'(rx_push) - 2'(rx_pop);
        end
    end

    // link state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= aal_pkg::AAL_IDLE;
            timer_q <= 32'h0;
            retry_cnt_q <= 4'h0;
            ack_addr_q <= 40'h0;
        end else begin
            if (timer_q != 32'h0) timer_q <= timer_q - 32'h1;
            case (state_q)
                aal_pkg::AAL_IDLE, aal_pkg::AAL_CLK_IDLE: begin
                    if (!cfg_pwr_q || !ce) begin
                        state_q <= aal_pkg::AAL_IDLE;
                    end else if (cfg_rx_q) begin
                        state_q <= aal_pkg::AAL_RX_SETTLE;
                        timer_q <= 32'(`AAL_SETTLE_CYC);
                    end else if (tx_cnt_q != 2'h0 && !status_q[`AAL_ST_RT])
                    begin
                        state_q <= aal_pkg::AAL_TX_SETTLE;
                        timer_q <= 32'(`AAL_SETTLE_CYC);
                        retry_cnt_q <= 4'h0;
                    end else begin
                        state_q <= aal_pkg::AAL_CLK_IDLE;
                    end
                end
                aal_pkg::AAL_TX_SETTLE: begin
                    if (timer_q == 32'h0) state_q <= aal_pkg::AAL_TX_SEND;
                end
                aal_pkg::AAL_TX_SEND: begin
                    if (air_tx_done) begin
                        if (auto_ack_q[0]) begin
                            state_q <= aal_pkg::AAL_ACK_WAIT;
                            timer_q <= (32'(retr_q[7:4]) + 32'h1)
                                * 32'(`AAL_WAIT_UNIT_CYC);
                        end else begin
                            state_q <= aal_pkg::AAL_IDLE;
                        end
                    end
                end
                aal_pkg::AAL_ACK_WAIT: begin
                    if (tx_pop) begin
                        state_q <= aal_pkg::AAL_IDLE;
                    end else if (timer_q == 32'h0) begin
                        if (!cfg_retx_q || retry_cnt_q >= retr_q[3:0]) begin
                            state_q <= aal_pkg::AAL_IDLE;
                        end else begin
                            retry_cnt_q <= retry_cnt_q + 4'h1;
                            state_q <= aal_pkg::AAL_RETRY_GAP;
                            timer_q <= (32'(retr_q[7:4]) + 32'h1)
                                * 32'(`AAL_WAIT_UNIT_CYC);
                        end
                    end
                end
                aal_pkg::AAL_RETRY_GAP: begin
                    if (timer_q == 32'h0) state_q <= aal_pkg::AAL_TX_SEND;
                end
                aal_pkg::AAL_RX_SETTLE: begin
                    if (!ce) state_q <= aal_pkg::AAL_IDLE;
                    else if (timer_q == 32'h0)
                        state_q <= aal_pkg::AAL_RX_LISTEN;
                end
                aal_pkg::AAL_RX_LISTEN: begin
                    if (!ce || !cfg_rx_q) begin
                        state_q <= aal_pkg::AAL_IDLE;
                    end else if (rx_ok && auto_ack_q[hit_pipe]) begin
                        state_q <= aal_pkg::AAL_ACK_SEND;
                        ack_addr_q <= air_rx_address;
                    end
                end
                aal_pkg::AAL_ACK_SEND: begin
                    if (air_tx_done) state_q <= aal_pkg::AAL_IDLE;
                end
                default: state_q <= aal_pkg::AAL_IDLE;
            endcase
        end
    end

    // status flags, set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= 3'h0;
            rx_pipe_q <= 3'h7;
            lost_cnt_q <= 4'h0;
        end else begin
            logic [2:0] set;
            logic lost;
            set = 3'h0;
            lost = state_q == aal_pkg::AAL_ACK_WAIT && !tx_pop
                && timer_q == 32'h0
                && (!cfg_retx_q || retry_cnt_q >= retr_q[3:0]);
            set[`AAL_ST_RX] = rx_ok;
            set[`AAL_ST_TX] = tx_pop
                || (state_q == aal_pkg::AAL_TX_SEND && air_tx_done
                    && !auto_ack_q[0]);
            set[`AAL_ST_RT] = lost;
            if (wr_go && awaddr_q == `AAL_OFF_STATUS)
                status_q <= (status_q & ~wdata_q[2:0]) | set;
            else
                status_q <= status_q | set;
            if (rx_ok) rx_pipe_q <= hit_pipe;
            else if (rx_cnt_q == 2'h0) rx_pipe_q <= 3'h7;
            if (wr_go && awaddr_q == `AAL_OFF_CHANNEL)
                lost_cnt_q <= 4'h0;
            else if (lost && lost_cnt_q != 4'hf)
                lost_cnt_q <= lost_cnt_q + 4'h1;
        end
    end
    assign irq_n = status_q == 3'h0;

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `AAL_OFF_CONFIG: s_axi_rdata <= {28'h0, cfg_retx_q,
                    cfg_rate_q, cfg_pwr_q, cfg_rx_q};
                `AAL_OFF_AUTO_ACK: s_axi_rdata <= {26'h0, auto_ack_q};
                `AAL_OFF_PIPE_EN: s_axi_rdata <= {26'h0, pipe_en_q};
                `AAL_OFF_RETR: s_axi_rdata <= {24'h0, retr_q};
                `AAL_OFF_CHANNEL: s_axi_rdata <= {24'h0, channel_q};
                `AAL_OFF_STATUS: s_axi_rdata <= {20'h0, tx_cnt_q, rx_cnt_q,
                    1'b0, rx_pipe_q, 1'b0, status_q};
                `AAL_OFF_COUNTS: s_axi_rdata <= {24'h0, lost_cnt_q,
                    retry_cnt_q};
                `AAL_OFF_P0_LO: s_axi_rdata <= p0_addr_q[31:0];
                `AAL_OFF_P0_HI: s_axi_rdata <= {24'h0, p0_addr_q[39:32]};
                `AAL_OFF_P1_LO: s_axi_rdata <= p1_addr_q[31:0];
                `AAL_OFF_P1_HI: s_axi_rdata <= {24'h0, p1_addr_q[39:32]};
                `AAL_OFF_P_LOW: s_axi_rdata <= p_low_q;
                `AAL_OFF_RX_POP: s_axi_rdata <= rx_mem_q[0];
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // air side outputs
    assign air_tx_valid = state_q == aal_pkg::AAL_TX_SEND
        || state_q == aal_pkg::AAL_ACK_SEND;
    assign air_tx_is_ack = state_q == aal_pkg::AAL_ACK_SEND;
    assign air_tx_address = air_tx_is_ack ? ack_addr_q : p0_addr_q;
    assign air_tx_payload = air_tx_is_ack ? 32'h0 : tx_mem_q[0];
    assign radio_power = state_q != aal_pkg::AAL_IDLE
        && state_q != aal_pkg::AAL_CLK_IDLE;
    assign osc_16m_enable = state_q != aal_pkg::AAL_IDLE;
    assign air_rate_2m = cfg_rate_q;
endmodule : aal_engine

/* common/aal_consts.svh */
// constants for the auto-ack packet link engine
// Function
// - receiver accepts packets on six addressed pipes
// - pipe zero 40-bit address, others share upper
// - ack sent with receiving pipe's address
// - after send, listen for ack, resend
// - retry limit passed: flag, irq, keep payload
// - ack received: drop payload, set sent flag
// - payload length equals bytes written in burst; here a fixed 32-bit word per push
// - transmit start powers radio, sends at rate
// - irq pin active while flags set
// - no sending until exhausted flag cleared
// - lost counter counts exhausted events
// - after send: idle, next payload or clocked idle
// - receive begins 130us after chip enable
// - valid packet stored, flag, irq, pipe number
// - auto ack sends ack then resumes mode
// - auto ack enabled per pipe
// - channel write clears lost counter
// - clocked idle with chip enable, empty fifo
`ifndef AAL_CONSTS_SVH
`define AAL_CONSTS_SVH
`define AAL_CLK_MHZ 100
`define AAL_SETTLE_US 130
`define AAL_SETTLE_CYC (`AAL_SETTLE_US * `AAL_CLK_MHZ)
`define AAL_CE_MIN_US 10
`define AAL_CE_MIN_CYC (`AAL_CE_MIN_US * `AAL_CLK_MHZ)
`define AAL_WAIT_UNIT_CYC 25000
`define AAL_PIPES 6
`define AAL_FIFO_DEPTH 3
`define AAL_OFF_CONFIG 32'h00
`define AAL_OFF_AUTO_ACK 32'h04
`define AAL_OFF_PIPE_EN 32'h08
`define AAL_OFF_RETR 32'h0c
`define AAL_OFF_CHANNEL 32'h10
`define AAL_OFF_STATUS 32'h14
`define AAL_OFF_COUNTS 32'h18
`define AAL_OFF_P0_LO 32'h1c
`define AAL_OFF_P0_HI 32'h20
`define AAL_OFF_P1_LO 32'h24
`define AAL_OFF_P1_HI 32'h28
`define AAL_OFF_P_LOW 32'h2c
`define AAL_OFF_TX_PUSH 32'h30
`define AAL_OFF_RX_POP 32'h34
`define AAL_ST_RX 0
`define AAL_ST_TX 1
`define AAL_ST_RT 2
`define AAL_PIPE_ENABLE_RST 6'h03
`define AAL_AUTO_ACK_RST 6'h3f
`define AAL_RETR_RST 8'h03
`endif

/* common/aal_pkg.sv */
// types for the auto-ack packet link engine
package aal_pkg;
    typedef enum logic [3:0] {
        AAL_IDLE, AAL_CLK_IDLE, AAL_TX_SETTLE, AAL_TX_SEND, AAL_ACK_WAIT,
        AAL_RETRY_GAP, AAL_RX_SETTLE, AAL_RX_LISTEN, AAL_ACK_SEND
    } aal_state_t;
endpackage : aal_pkg

/* rtl/aal_sync.sv */
// two-flop synchroniser with edge detect
`timescale 1ns/1ps
module aal_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic din,
    output logic dout,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    // first flop feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign dout = sync_q;
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
endmodule : aal_sync

/* dv/aal_engine_asserts.sv */
// link engine port assertions
`timescale 1ns/1ps
module aal_engine_asserts (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic air_tx_valid,
    input logic [39:0] air_tx_address,
    input logic [31:0] air_tx_payload,
    input logic air_tx_is_ack,
    input logic air_tx_done,
    input logic air_rx_valid,
    input logic [39:0] air_rx_address,
    input logic air_rx_crc_ok,
    input logic air_rx_is_ack,
    input logic radio_power,
    input logic osc_16m_enable
);
    logic [39:0] rx_addr_q;
    logic rx_seen_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // last good payload address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_addr_q <= 40'h0;
            rx_seen_q <= 1'b0;
        end else if (air_rx_valid && air_rx_crc_ok && !air_rx_is_ack) begin
            rx_addr_q <= air_rx_address;
            rx_seen_q <= 1'b1;
        end else if (air_tx_done && air_tx_is_ack) begin
            rx_seen_q <= 1'b0;
        end
    end
    tx_hold_a: assert property (
        air_tx_valid && !air_tx_done |=> air_tx_valid)
        else $error("frame dropped");
    tx_stable_a: assert property (
        air_tx_valid && !air_tx_done |=>
        $stable(air_tx_payload) && $stable(air_tx_address))
        else $error("frame changed");
    tx_power_a: assert property (
        air_tx_valid |-> radio_power && osc_16m_enable)
        else $error("frame unpowered");
    ack_addr_a: assert property (
        air_tx_valid && air_tx_is_ack |-> air_tx_address == rx_addr_q)
        else $error("ack address");
    ack_cause_a: assert property (
        $rose(air_tx_valid) && air_tx_is_ack |-> rx_seen_q)
        else $error("stray ack");
    bad_crc_a: assert property (
        air_rx_valid && !air_rx_crc_ok && !air_tx_valid |=> !air_tx_valid)
        else $error("bad crc acked");
    wr_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid)
        else $error("bresp late");
    wr_block_a: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write in resp");
    rd_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rdata late");
    rd_block_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read in data");
endmodule : aal_engine_asserts

bind aal_engine aal_engine_asserts chk_u (.*);

/* dv/aal_air_peer.sv */
// far-side radio peer: finishes and acks frames
`timescale 1ns/1ps
module aal_air_peer (
    input logic aclk,
    input logic air_tx_valid,
    input logic [39:0] air_tx_address,
    input logic air_tx_is_ack,
    input logic ack_on,
    input logic [7:0] done_dly,
    output logic air_tx_done,
    output logic air_rx_valid,
    output logic [39:0] air_rx_address,
    output logic [31:0] air_rx_payload,
    output logic air_rx_crc_ok,
    output logic air_rx_is_ack
);
    logic [7:0] cnt_q;
    logic [39:0] ack_adr;
    // one-cycle frame, then scrambled lines
    task automatic send_frame(input logic [39:0] a, input logic [31:0] d,
                              input logic ok, ak);
        air_rx_valid <= 1'b1;
        air_rx_address <= a;
        air_rx_payload <= d;
        air_rx_crc_ok <= ok;
        air_rx_is_ack <= ak;
        @(posedge aclk);
        air_rx_valid <= 1'b0;
        air_rx_address <= ~a;
        air_rx_payload <= ~d;
        air_rx_crc_ok <= ~ok;
    endtask : send_frame
    // quiet lines
    initial begin
        {air_rx_valid, air_rx_crc_ok, air_rx_is_ack} = 3'h0;
        {air_rx_address, air_rx_payload} = 72'h0;
    end
    // done pulses after done_dly + 1 cycles of valid
    always @(posedge aclk) begin
        air_tx_done <= 1'b0;
        cnt_q <= 8'h0;
        if (air_tx_valid && !air_tx_done) begin
            cnt_q <= cnt_q + 8'h1;
            air_tx_done <= cnt_q == done_dly;
        end
    end
    // ack finished payload frames
    initial forever begin
        @(posedge aclk);
        if (air_tx_done && air_tx_valid && !air_tx_is_ack && ack_on) begin
            ack_adr = air_tx_address;
            repeat (20) @(posedge aclk);
            send_frame(ack_adr, 32'h0, 1'b1, 1'b1);
        end
    end
endmodule : aal_air_peer

/* dv/tb_auto_ack_packet_link_engine.sv */
// bench: tx with ack, retry exhaustion, rx with auto ack
`timescale 1ns/1ps
`include "aal_consts.svh"
module tb_auto_ack_packet_link_engine;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr, s_axi_wdata;
    logic [31:0] s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, chip_enable = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq_n, air_tx_valid, air_tx_is_ack, air_tx_done;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [39:0] air_tx_address, air_rx_address;
    logic [31:0] air_tx_payload, air_rx_payload;
    logic air_rx_valid, air_rx_crc_ok, air_rx_is_ack, radio_power;
    logic osc_16m_enable, air_rate_2m, ack_on = 1'b1;
    logic [7:0] done_dly = 8'h8;
    logic [79:0] fr;
    int fails = 0, total_checks = 0;
    // clock
    always #5 aclk = ~aclk;
    aal_engine dut_u (.*);
    aal_air_peer peer_u (.*);
    task automatic complete_run();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic give_up();
        fails++;
        $display("[ERR] t=%0t timeout", $time);
        complete_run();
    endtask : give_up
    task automatic chk(input logic [79:0] g, e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    function automatic logic [31:0] st(input logic [2:0] f, p,
                                       input logic [1:0] rc, tc);
        return {20'h0, tc, rc, 1'b0, p, 1'b0, f};
    endfunction : st
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        bit ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 60 && !ok; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                ok = 1'b1;
            end
        end
        if (!ok) give_up();
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        bit ok = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 60 && !ok; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                ok = 1'b1;
            end
        end
        if (!ok) give_up();
    endtask : axi_rd
    task automatic rd_chk(input logic [31:0] a, m, e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk({r, d & m}, {2'h0, e & m});
    endtask : rd_chk
    task automatic wait_frame(input int lim, input bit must, output bit got);
        int n = 0;
        while (air_tx_valid !== 1'b1 && n < lim) begin
            @(posedge aclk);
            n++;
        end
        got = air_tx_valid === 1'b1;
        fr = {5'h0, air_rate_2m, radio_power & osc_16m_enable, air_tx_is_ack,
              air_tx_address, air_tx_payload};
        while (air_tx_valid === 1'b1 && n < lim + 500) begin
            @(posedge aclk);
            n++;
        end
        if (must && !got) give_up();
    endtask : wait_frame
    task automatic wait_irq(input int lim);
        for (int n = 0; n < lim && irq_n !== 1'b0; n++) @(posedge aclk);
        if (irq_n !== 1'b0) give_up();
    endtask : wait_irq
    task automatic ce_pulse();
        chip_enable <= 1'b1;
        repeat (`AAL_CE_MIN_CYC + 100) @(posedge aclk);
        chip_enable <= 1'b0;
    endtask : ce_pulse
    // main sequence
    initial begin
        logic [31:0] d, pl0, pl1;
        logic [1:0] r;
        logic [39:0] adr;
        logic rate;
        bit got;
        void'($urandom(32'h6224ceae));
        adr = {8'($urandom), $urandom};
        pl0 = $urandom;
        pl1 = $urandom;
        rate = 1'($urandom);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(`AAL_OFF_AUTO_ACK, 32'h3f, 32'h3f);
        rd_chk(`AAL_OFF_PIPE_EN, 32'h3f, 32'h03);
        rd_chk(`AAL_OFF_RETR, 32'hff, 32'h03);
        rd_chk(`AAL_OFF_STATUS, 32'hf77, st(3'h0, 3'h7, 2'h0, 2'h0));
        axi_rd(32'h40, d, r);
        chk(r, 2'h2);
        $display("test reset done");
        done_dly <= 8'd5 + 8'($urandom_range(40));
        axi_wr(`AAL_OFF_P0_LO, adr[31:0]);
        axi_wr(`AAL_OFF_P0_HI, {24'h0, adr[39:32]});
        axi_wr(`AAL_OFF_CONFIG, {28'h0, 1'b1, rate, 2'b10});
        axi_wr(`AAL_OFF_TX_PUSH, pl0);
        axi_wr(`AAL_OFF_TX_PUSH, pl1);
        chip_enable <= 1'b1;
        wait_frame(20000, 1'b1, got);
        chk(fr, {5'h0, rate, 2'b10, adr, pl0});
        wait_frame(20000, 1'b1, got);
        chk(fr, {5'h0, rate, 2'b10, adr, pl1});
        repeat (80) @(posedge aclk);
        chk({irq_n, osc_16m_enable}, 2'b01);
        rd_chk(`AAL_OFF_STATUS, 32'hf07, st(3'h2, 3'h0, 2'h0, 2'h0));
        rd_chk(`AAL_OFF_COUNTS, 32'h0f, 32'h0);
        axi_wr(`AAL_OFF_STATUS, 32'h7);
        chip_enable <= 1'b0;
        repeat (8) @(posedge aclk);
        chk({irq_n, osc_16m_enable}, 2'b10);
        $display("test tx done");
        ack_on <= 1'b0;
        axi_wr(`AAL_OFF_RETR, 32'h0);
        axi_wr(`AAL_OFF_TX_PUSH, pl0);
        ce_pulse();
        wait_frame(20000, 1'b1, got);
        chk(fr[31:0], pl0);
        wait_irq(70000);
        rd_chk(`AAL_OFF_STATUS, 32'hf07, st(3'h4, 3'h0, 2'h0, 2'h1));
        rd_chk(`AAL_OFF_COUNTS, 32'hf0, 32'h10);
        ce_pulse();
        wait_frame(14500, 1'b0, got);
        chk(got, 1'b0);
        axi_wr(`AAL_OFF_STATUS, 32'h7);
        axi_wr(`AAL_OFF_CHANNEL, $urandom);
        rd_chk(`AAL_OFF_COUNTS, 32'hf0, 32'h0);
        ack_on <= 1'b1;
        ce_pulse();
        wait_frame(20000, 1'b1, got);
        chk(fr[31:0], pl0);
        repeat (80) @(posedge aclk);
        rd_chk(`AAL_OFF_STATUS, 32'hf07, st(3'h2, 3'h0, 2'h0, 2'h0));
        $display("test retry done");
        axi_wr(`AAL_OFF_STATUS, 32'h7);
        axi_wr(`AAL_OFF_CONFIG, 32'h3);
        chip_enable <= 1'b1;
        repeat (`AAL_SETTLE_CYC + 50) @(posedge aclk);
        peer_u.send_frame(adr, pl1, 1'b0, 1'b0);
        wait_frame(100, 1'b0, got);
        chk(got, 1'b0);
        peer_u.send_frame(adr, pl1, 1'b1, 1'b0);
        wait_frame(100, 1'b1, got);
        chk(fr[73:32], {2'b11, adr});
        rd_chk(`AAL_OFF_STATUS, 32'hf77, st(3'h1, 3'h0, 2'h1, 2'h0));
        chk(irq_n, 1'b0);
        rd_chk(`AAL_OFF_RX_POP, '1, pl1);
        axi_wr(`AAL_OFF_AUTO_ACK, 32'h3e);
        repeat (`AAL_SETTLE_CYC + 50) @(posedge aclk);
        peer_u.send_frame(adr, pl0, 1'b1, 1'b0);
        wait_frame(100, 1'b0, got);
        chk(got, 1'b0);
        rd_chk(`AAL_OFF_RX_POP, '1, pl0);
        chip_enable <= 1'b0;
        $display("test rx done");
        complete_run();
    end
endmodule : tb_auto_ack_packet_link_engine
